// ===== src/bit_sync.sv
// Two-flop synchroniser for a bus of independent level inputs.
// Assumes each bit is a slow level; no bit-to-bit coherence is promised.
`timescale 1ns/1ps
module bit_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [WIDTH-1:0] d_in,
   output logic [WIDTH-1:0] q_out
);

   // First stage, read only by the second stage.
   logic [WIDTH-1:0] meta_r;

   // One pair of flops per bit.
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_bit
         always_ff @(posedge clk) begin
            if (rst) begin
               meta_r[i] <= 1'b0;
               q_out[i] <= 1'b0;
            end else begin
               meta_r[i] <= d_in[i];
               q_out[i] <= meta_r[i];
            end
         end
      end
   endgenerate

endmodule

// ===== src/fault_encoder.sv
// Priority encoder from fault detector flags to an 8-bit fault code.
// Assumes synchronised flags; the lowest flag index wins when several are set.
`timescale 1ns/1ps
module fault_encoder import psu_lamp_pkg::*; (
   input wire logic [NUM_FAULTS-1:0] flags,
   output logic any_fault,
   output logic [CODE_W-1:0] code
);

   // Scan from the highest index down so the lowest set index is kept.
   always_comb begin
      any_fault = 1'b0;
      code = 8'h00;
      for (int i = NUM_FAULTS - 1; i >= 0; i--) begin
         if (flags[i]) begin
            any_fault = 1'b1;
            code = FAULT_CODE[i];
         end
      end
   end

endmodule

// ===== src/power_status_led_error_blinker.sv
// Power supply status lamps with a serial fault code on the DC input lamp.
// Assumes all status and fault inputs are asynchronous levels and rst is
// asserted by a full power-down of the controller.
//
// Functional notes
// - Battery lamp orange while charging on DC.
// - Battery lamp green when full on DC.
// - Low battery, power on: even orange blink.
// - Low battery, switch pressed, battery only: flash.
// - Lamps dark when no condition holds.
// - DC lamp green while adapter supplies power.
// - Any fault blinks DC lamp orange code.
// - Eight-bit code sent least significant bit first.
// - Two-second dark start; one long, zero short.
// - Adapter faults use codes 10h to 14h.
// - Battery faults use 20h-25h and 30h-35h.
// - Rail faults use 40h/45h, 50h-55h, 60h-65h.
// - Processor rails use 70h-73h and 80h-83h.
// - Memory rails use 90h-93h and A0h-A3h.
`timescale 1ns/1ps
module power_status_led_error_blinker import psu_lamp_pkg::*; #(
   parameter int unsigned START_GAP_CYC = START_GAP_DEF,
   parameter int unsigned ONE_ON_CYC = ONE_ON_DEF,
   parameter int unsigned ZERO_ON_CYC = ZERO_ON_DEF,
   parameter int unsigned BIT_GAP_CYC = BIT_GAP_DEF,
   parameter int unsigned BLINK_HALF_CYC = BLINK_HALF_DEF,
   parameter int unsigned FLASH_ON_CYC = FLASH_ON_DEF,
   parameter int unsigned FLASH_PERIOD_CYC = FLASH_PERIOD_DEF
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic dc_present,
   input wire logic batt_charging,
   input wire logic batt_full,
   input wire logic batt_low,
   input wire logic sys_power_on,
   input wire logic power_switch,
   input wire logic [NUM_FAULTS-1:0] fault_flags,
   output logic batt_lamp_green_r,
   output logic batt_lamp_orange_r,
   output logic dc_input_lamp_green_r,
   output logic dc_input_lamp_orange_r,
   output logic fault_active_r,
   output logic [CODE_W-1:0] fault_code_r
);

   // Synchronised copies of every status and fault pin input.
   logic [STAT_W+NUM_FAULTS-1:0] sync_q;
   logic s_dc;
   logic s_charging;
   logic s_full;
   logic s_low;
   logic s_on;
   logic s_switch;
   logic [NUM_FAULTS-1:0] s_faults;

   // Output of the fault priority encoder.
   logic enc_any;
   logic [CODE_W-1:0] enc_code;

   // Free running blink and flash timers for the battery lamp.
   logic [TMR_W-1:0] blink_cnt_r;
   logic blink_phase_r;
   logic [TMR_W-1:0] flash_cnt_r;
   logic flash_on;

   // Selected battery lamp mode.
   batt_mode_t batt_mode;

   // Fault frame sequencer state.
   frame_st_t st_r;
   logic [TMR_W-1:0] tmr_r;
   logic [IDX_W-1:0] idx_r;
   logic tmr_done;
   logic cur_bit;

   // Every status and fault pin passes two flops before any logic looks at it.
   bit_sync #(
      .WIDTH(STAT_W + NUM_FAULTS)
   ) u_sync (
      .clk(clk),
      .rst(rst),
      .d_in({fault_flags, power_switch, sys_power_on, batt_low,
             batt_full, batt_charging, dc_present}),
      .q_out(sync_q)
   );

   // Named views of the synchronised bus.
   assign s_dc = sync_q[0];
   assign s_charging = sync_q[1];
   assign s_full = sync_q[2];
   assign s_low = sync_q[3];
   assign s_on = sync_q[4];
   assign s_switch = sync_q[5];
   assign s_faults = sync_q[STAT_W+NUM_FAULTS-1:STAT_W];

   // Map the detector flags onto the one code to be shown.
   fault_encoder u_enc (
      .flags(s_faults),
      .any_fault(enc_any),
      .code(enc_code)
   );

   // Blink timer: the phase toggles every half period for equal on and off.
   always_ff @(posedge clk) begin
      if (rst) begin
         blink_cnt_r <= '0;
         blink_phase_r <= 1'b0;
      end else if (blink_cnt_r == TMR_W'(BLINK_HALF_CYC - 1)) begin
         blink_cnt_r <= '0;
         blink_phase_r <= ~blink_phase_r;
      end else begin
         blink_cnt_r <= blink_cnt_r + 1'b1;
      end
   end

   // Flash timer: a short on time at the start of each flash period.
   always_ff @(posedge clk) begin
      if (rst) begin
         flash_cnt_r <= '0;
      end else if (flash_cnt_r == TMR_W'(FLASH_PERIOD_CYC - 1)) begin
         flash_cnt_r <= '0;
      end else begin
         flash_cnt_r <= flash_cnt_r + 1'b1;
      end
   end

   // The flash is lit only in the first part of its period.
   assign flash_on = (flash_cnt_r < TMR_W'(FLASH_ON_CYC));

   // Battery lamp mode by priority; charge states on DC outrank low battery.
   always_comb begin
      batt_mode = BM_DARK;
      if (s_dc && s_full) begin
         batt_mode = BM_GREEN;
      end else if (s_dc && s_charging) begin
         batt_mode = BM_ORANGE;
      end else if (s_low && s_switch && !s_dc) begin
         batt_mode = BM_FLASH;
      end else if (s_low && s_on) begin
         batt_mode = BM_BLINK;
      end
   end

   // Battery lamp colours, registered straight from the selected mode.
   always_ff @(posedge clk) begin
      if (rst) begin
         batt_lamp_green_r <= 1'b0;
         batt_lamp_orange_r <= 1'b0;
      end else begin
         case (batt_mode)
            BM_GREEN: begin
               batt_lamp_green_r <= 1'b1;
               batt_lamp_orange_r <= 1'b0;
            end
            BM_ORANGE: begin
               batt_lamp_green_r <= 1'b0;
               batt_lamp_orange_r <= 1'b1;
            end
            BM_BLINK: begin
               batt_lamp_green_r <= 1'b0;
               batt_lamp_orange_r <= blink_phase_r;
            end
            BM_FLASH: begin
               batt_lamp_green_r <= 1'b0;
               batt_lamp_orange_r <= flash_on;
            end
            default: begin
               batt_lamp_green_r <= 1'b0;
               batt_lamp_orange_r <= 1'b0;
            end
         endcase
      end
   end

   // First fault is caught and held; only reset lets it go.
   always_ff @(posedge clk) begin
      if (rst) begin
         fault_active_r <= 1'b0;
         fault_code_r <= 8'h00;
      end else if (!fault_active_r && enc_any) begin
         fault_active_r <= 1'b1;
         fault_code_r <= enc_code;
      end
   end

   // The timer of the current phase has run out.
   assign tmr_done = (tmr_r == '0);

   // Bit now on the lamp, taken from the low end upward.
   assign cur_bit = fault_code_r[idx_r];

   // Frame sequencer: start gap, then eight pulses with gaps, then repeat.
   always_ff @(posedge clk) begin
      if (rst) begin
         st_r <= ST_IDLE;
         tmr_r <= '0;
         idx_r <= FIRST_BIT;
      end else begin
         case (st_r)
            ST_IDLE: begin
               if (enc_any) begin // Leave with the latch so the dark lead-in is exact.
                  st_r <= ST_START;
                  tmr_r <= TMR_W'(START_GAP_CYC - 1);
                  idx_r <= FIRST_BIT;
               end
            end
            ST_START: begin
               if (tmr_done) begin
                  st_r <= ST_PULSE;
                  tmr_r <= cur_bit ? TMR_W'(ONE_ON_CYC - 1) : TMR_W'(ZERO_ON_CYC - 1);
               end else begin
                  tmr_r <= tmr_r - 1'b1;
               end
            end
            ST_PULSE: begin
               if (tmr_done && idx_r == LAST_BIT) begin
                  st_r <= ST_START;
                  tmr_r <= TMR_W'(START_GAP_CYC - 1);
                  idx_r <= FIRST_BIT;
               end else if (tmr_done) begin
                  st_r <= ST_GAP;
                  tmr_r <= TMR_W'(BIT_GAP_CYC - 1);
               end else begin
                  tmr_r <= tmr_r - 1'b1;
               end
            end
            ST_GAP: begin
               if (tmr_done) begin
                  st_r <= ST_PULSE;
                  idx_r <= idx_r + 1'b1;
                  tmr_r <= fault_code_r[idx_r + 1'b1] ? TMR_W'(ONE_ON_CYC - 1)
                                                      : TMR_W'(ZERO_ON_CYC - 1);
               end else begin
                  tmr_r <= tmr_r - 1'b1;
               end
            end
            default: begin
               st_r <= ST_IDLE;
               tmr_r <= '0;
               idx_r <= FIRST_BIT;
            end
         endcase
      end
   end

   // DC input lamp: orange code pulses while a fault is held, else green on DC.
   always_ff @(posedge clk) begin
      if (rst) begin
         dc_input_lamp_green_r <= 1'b0;
         dc_input_lamp_orange_r <= 1'b0;
      end else if (fault_active_r) begin
         dc_input_lamp_green_r <= 1'b0;
         dc_input_lamp_orange_r <= (st_r == ST_PULSE);
      end else begin
         dc_input_lamp_green_r <= s_dc;
         dc_input_lamp_orange_r <= 1'b0;
      end
   end

   // Helper: lit and dark stretch lengths; counting starts two cycles after fault_active_r is set.
   logic [TMR_W-1:0] on_len_r;
   logic [TMR_W-1:0] off_len_r;
   always_ff @(posedge clk) begin
      if (rst || !$past(fault_active_r)) begin
         on_len_r <= '0;
         off_len_r <= '0;
      end else if (dc_input_lamp_orange_r) begin
         on_len_r <= on_len_r + 1'b1;
         off_len_r <= '0;
      end else begin
         on_len_r <= '0;
         off_len_r <= off_len_r + 1'b1;
      end
   end

   // Helper: bit value of the pulse that is now lit.
   logic lit_bit_r;
   always_ff @(posedge clk) begin
      if (rst) begin
         lit_bit_r <= 1'b0;
      end else begin
         lit_bit_r <= cur_bit;
      end
   end

   // All checks share the one clock and the one reset.
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   // Battery lamp checks.
   a_green_when_full: assert property (
      s_dc && s_full |=> batt_lamp_green_r && !batt_lamp_orange_r)
      else $error("battery lamp not green when full on DC");

   a_orange_charging: assert property (
      s_dc && s_charging && !s_full |=> batt_lamp_orange_r && !batt_lamp_green_r)
      else $error("battery lamp not orange while charging");

   a_blink_follows: assert property (
      batt_mode == BM_BLINK |=> batt_lamp_orange_r == $past(blink_phase_r))
      else $error("battery lamp blink does not follow blink phase");

   a_blink_half: assert property (
      $changed(blink_phase_r) |-> $past(blink_cnt_r) == TMR_W'(BLINK_HALF_CYC - 1))
      else $error("blink half period has the wrong length");

   a_flash_low_switch: assert property (
      s_low && s_switch && !s_dc |=> batt_lamp_orange_r == $past(flash_on))
      else $error("battery lamp does not flash on low battery switch press");

   a_dark_otherwise: assert property (
      batt_mode == BM_DARK |=> !batt_lamp_orange_r && !batt_lamp_green_r)
      else $error("battery lamp lit with no condition");

   // DC input lamp checks.
   a_dc_green: assert property (
      s_dc && !fault_active_r |=> dc_input_lamp_green_r)
      else $error("DC lamp not green with adapter present");

   a_fault_no_green: assert property (
      fault_active_r |=> !dc_input_lamp_green_r)
      else $error("DC lamp green while a fault is shown");

   a_pulse_width: assert property (
      $fell(dc_input_lamp_orange_r) && fault_active_r |->
         on_len_r == ($past(lit_bit_r, 2) ? ONE_ON_CYC : ZERO_ON_CYC))
      else $error("code pulse width does not match the bit");

   a_gap_length: assert property (
      $rose(dc_input_lamp_orange_r) && $past(off_len_r) > 0 |->
         $past(off_len_r) + 1 == BIT_GAP_CYC || $past(off_len_r) + 1 == START_GAP_CYC)
      else $error("dark stretch before a pulse has the wrong length");

   a_lsb_first: assert property (
      st_r == ST_START && tmr_done |=> st_r == ST_PULSE && idx_r == FIRST_BIT)
      else $error("frame does not open with the lowest bit");

   a_frame_repeat: assert property (
      st_r == ST_PULSE && tmr_done && idx_r == LAST_BIT |=> st_r == ST_START)
      else $error("frame does not repeat after the last bit");

   a_code_held: assert property (
      fault_active_r |=> fault_active_r && $stable(fault_code_r))
      else $error("latched fault code changed before reset");

   // Main scenarios.
   c_fault_frame: cover property (st_r == ST_PULSE && tmr_done && idx_r == LAST_BIT);
   c_blink: cover property (batt_mode == BM_BLINK ##1 batt_lamp_orange_r);
   c_flash: cover property (batt_mode == BM_FLASH ##1 batt_lamp_orange_r);
   c_green: cover property (dc_input_lamp_green_r && batt_lamp_green_r);

endmodule

// ===== src/psu_lamp_pkg.sv
// Constants, timing figures, fault code table and state types for the lamp block.
// Assumes a single 50 MHz system clock shared by every user of this package.
package psu_lamp_pkg;

   // System clock rate and the derived cycles per millisecond.
   localparam int unsigned CLK_HZ = 50_000_000;
   localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;

   // Times of the fault code frame, in milliseconds.
   localparam int unsigned START_GAP_MS = 2000;
   localparam int unsigned ONE_ON_MS = 1000;
   localparam int unsigned ZERO_ON_MS = 500;
   localparam int unsigned BIT_GAP_MS = 500;

   // Times of the battery lamp blink and flash, in milliseconds.
   localparam int unsigned BLINK_HALF_MS = 500;
   localparam int unsigned FLASH_ON_MS = 100;
   localparam int unsigned FLASH_PERIOD_MS = 400;

   // Default cycle counts derived from the times above.
   localparam int unsigned START_GAP_DEF = START_GAP_MS * CYC_PER_MS;
   localparam int unsigned ONE_ON_DEF = ONE_ON_MS * CYC_PER_MS;
   localparam int unsigned ZERO_ON_DEF = ZERO_ON_MS * CYC_PER_MS;
   localparam int unsigned BIT_GAP_DEF = BIT_GAP_MS * CYC_PER_MS;
   localparam int unsigned BLINK_HALF_DEF = BLINK_HALF_MS * CYC_PER_MS;
   localparam int unsigned FLASH_ON_DEF = FLASH_ON_MS * CYC_PER_MS;
   localparam int unsigned FLASH_PERIOD_DEF = FLASH_PERIOD_MS * CYC_PER_MS;

   // Widths of the timers, the code and the bit index.
   localparam int TMR_W = 32;
   localparam int CODE_W = 8;
   localparam int IDX_W = 3;
   localparam logic [IDX_W-1:0] FIRST_BIT = 3'h0;
   localparam logic [IDX_W-1:0] LAST_BIT = 3'h7;

   // Status inputs: DC present, charging, full, low, power on, switch.
   localparam int STAT_W = 6;

   // Fault detector flags, one per entry of the code table below.
   localparam int NUM_FAULTS = 47;

   // Code sent for each fault flag; flag 0 has the highest priority.
   localparam logic [CODE_W-1:0] FAULT_CODE [NUM_FAULTS] = '{
      8'h10, 8'h11, 8'h12, 8'h13, 8'h14,
      8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25,
      8'h30, 8'h31, 8'h32, 8'h33, 8'h34, 8'h35,
      8'h40, 8'h45,
      8'h50, 8'h51, 8'h52, 8'h53, 8'h54, 8'h55,
      8'h60, 8'h61, 8'h62, 8'h63, 8'h64, 8'h65,
      8'h70, 8'h71, 8'h72, 8'h73,
      8'h80, 8'h81, 8'h82, 8'h83,
      8'h90, 8'h91, 8'h92, 8'h93,
      8'hA0, 8'hA1, 8'hA2, 8'hA3
   };

   // Phases of one fault code frame.
   typedef enum logic [1:0] {ST_IDLE, ST_START, ST_PULSE, ST_GAP} frame_st_t;

   // Display modes of the battery lamp.
   typedef enum logic [2:0] {BM_DARK, BM_ORANGE, BM_GREEN, BM_BLINK, BM_FLASH} batt_mode_t;

endpackage

// ===== test/lamp_code_reader.sv
// Far-side model of the DC input lamp: reads the orange pulses back into a code.
// Assumes the lamp is a register on clk and the same timing parameters as the design.
`timescale 1ns/1ps
module lamp_code_reader #(
   parameter int START = 40,
   parameter int ONE = 20,
   parameter int ZERO = 10,
   parameter int GAP = 10
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic orange,
   output logic dec_valid,
   output logic dec_ok,
   output logic [7:0] dec_code
);
   logic prev_r; // Lamp level at the previous edge.
   logic synced_r; // Set once a start gap of exact length is seen.
   int run_r; // Edges since the lamp last changed.
   int idx_r; // Index of the next bit of the frame.

   // Times each run of the lamp and turns pulse lengths into bits.
   always @(posedge clk) begin
      dec_valid = 1'b0;
      if (rst) begin
         prev_r = 1'b0;
         synced_r = 1'b0;
         run_r = 0;
         idx_r = 0;
         dec_ok = 1'b0;
         dec_code = 8'h00;
      end else if (orange !== prev_r) begin
         if (orange) begin
            // A rise ends a dark run, which is a start gap or a bit gap.
            if (run_r == START) begin
               synced_r = 1'b1;
               idx_r = 0;
               dec_ok = 1'b1;
            end else if (synced_r && !(run_r == GAP && idx_r > 0 && idx_r < 8)) begin
               dec_ok = 1'b0;
               dec_valid = 1'b1;
               synced_r = 1'b0;
            end
         end else if (synced_r && idx_r < 8) begin
            // A fall ends a pulse: the long one is a one, the short one a zero.
            if (run_r != ONE && run_r != ZERO) begin
               dec_ok = 1'b0;
            end
            dec_code[idx_r[2:0]] = (run_r == ONE);
            idx_r = idx_r + 1;
            dec_valid = (idx_r == 8);
         end
         prev_r = orange;
         run_r = 1;
      end else if (run_r < 4000) begin
         run_r = run_r + 1;
      end
   end
endmodule

// ===== test/power_status_led_error_blinker_test.sv
// Self-checking bench for the power status lamps and the serial fault code.
// Assumes shortened timing parameters and a 50 MHz clock.
`timescale 1ns/1ps
module power_status_led_error_blinker_test;
   import psu_lamp_pkg::*;
   localparam int SG = 40; // Start gap in cycles.
   localparam int ON1 = 20; // Pulse of a one bit.
   localparam int ON0 = 10; // Pulse of a zero bit.
   localparam int BG = 10; // Gap between bits.
   logic clk, rst, dc_present, batt_charging, batt_full, batt_low, sys_power_on, power_switch;
   logic [NUM_FAULTS-1:0] fault_flags, f; // Detector flags and their next value.
   logic batt_lamp_green_r, batt_lamp_orange_r, dc_input_lamp_green_r, dc_input_lamp_orange_r;
   logic fault_active_r, dec_valid, dec_ok;
   logic [CODE_W-1:0] fault_code_r, dec_code, exp;
   logic [8:0] exp_q[$]; // Expected frames: timing ok bit and code.
   logic [8:0] e; // Oldest expected frame.
   logic [31:0] r; // Random draw.
   int seed = 32'h236f; // Fixed seed for the random stream.
   int n_errors = 0;
   int comparisons = 0;
   int n_or; // Lit cycles counted on the battery lamp.
   // Status stimulus {dc, charging, full, low, power on, switch} and {bg, bo, dg}.
   logic [5:0] st_in[8] = '{6'h20, 6'h30, 6'h32, 6'h28, 6'h2A, 6'h02, 6'h04, 6'h25};
   logic [2:0] st_ex[8] = '{3'h1, 3'h3, 3'h3, 3'h5, 3'h5, 3'h0, 3'h0, 3'h1};
   // First flag index and code of each fault group.
   int grp_at[11] = '{0, 5, 11, 17, 18, 19, 25, 31, 35, 39, 43};
   logic [7:0] grp_code[11] = '{8'h10, 8'h20, 8'h30, 8'h40, 8'h45, 8'h50, 8'h60, 8'h70, 8'h80,
                                8'h90, 8'hA0};

   power_status_led_error_blinker #(.START_GAP_CYC(SG), .ONE_ON_CYC(ON1), .ZERO_ON_CYC(ON0),
      .BIT_GAP_CYC(BG), .BLINK_HALF_CYC(8), .FLASH_ON_CYC(2), .FLASH_PERIOD_CYC(8)) DUT (
      .clk(clk), .rst(rst), .dc_present(dc_present), .batt_charging(batt_charging),
      .batt_full(batt_full), .batt_low(batt_low), .sys_power_on(sys_power_on),
      .power_switch(power_switch), .fault_flags(fault_flags),
      .batt_lamp_green_r(batt_lamp_green_r), .batt_lamp_orange_r(batt_lamp_orange_r),
      .dc_input_lamp_green_r(dc_input_lamp_green_r),
      .dc_input_lamp_orange_r(dc_input_lamp_orange_r),
      .fault_active_r(fault_active_r), .fault_code_r(fault_code_r));

   lamp_code_reader #(.START(SG), .ONE(ON1), .ZERO(ON0), .GAP(BG)) reader (
      .clk(clk), .rst(rst), .orange(dc_input_lamp_orange_r),
      .dec_valid(dec_valid), .dec_ok(dec_ok), .dec_code(dec_code));

   // Free-running 50 MHz clock.
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // Compares one value and counts the outcome.
   task automatic check(input logic [7:0] seen, input logic [7:0] want, input string what);
      comparisons++;
      if (seen !== want) begin
         n_errors++;
         $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, want);
      end
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic close_out();
      $display("Comparisons %0d, mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // Holds reset for five edges with all detector flags clear.
   task automatic do_reset();
      @(posedge clk);
      rst <= 1'b1;
      fault_flags <= '0;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
   endtask

   // Drives the six status levels on a rising edge.
   task automatic set_stat(input logic [5:0] s);
      @(posedge clk);
      {dc_present, batt_charging, batt_full, batt_low, sys_power_on, power_switch} <= s;
   endtask

   // Waits, under a bound, until the reader has delivered every expected frame.
   task automatic wait_q();
      int k;
      k = 0;
      while (exp_q.size() > 0 && k < 1200) begin
         @(negedge clk);
         k++;
      end
      check(8'(exp_q.size()), 8'h00, "code frame missing");
   endtask

   // Expected code of a flag index, from the group table.
   function automatic logic [7:0] code_of(input int i);
      logic [7:0] c;
      c = 8'h00;
      for (int g = 0; g < 11; g++) begin
         if (i >= grp_at[g]) c = grp_code[g] + 8'(i - grp_at[g]);
      end
      return c;
   endfunction

   // Takes the oldest expected frame whenever the reader delivers one.
   always @(negedge clk) begin
      if (dec_valid === 1'b1) begin
         if (exp_q.size() == 0) begin
            check(8'h00, 8'h01, "frame not expected");
         end else begin
            e = exp_q.pop_front();
            check({7'h0, dec_ok}, {7'h0, e[8]}, "frame timing");
            check(dec_code, e[7:0], "sent code");
         end
      end
   end

   // Cuts a hang short well beyond the expected run time.
   initial begin
      #(60000 * 20);
      n_errors++;
      close_out();
   end

   // Main sequence: reset, steady lamps, blink, flash, then every fault code.
   initial begin
      rst = 1'b1;
      {dc_present, batt_charging, batt_full, batt_low, sys_power_on, power_switch} = 6'h00;
      fault_flags = '0;
      do_reset();
      @(negedge clk);
      check({2'h0, batt_lamp_green_r, batt_lamp_orange_r, dc_input_lamp_green_r,
             dc_input_lamp_orange_r, fault_active_r, |fault_code_r}, 8'h00, "after reset");
      for (int t = 0; t < 8; t++) begin
         set_stat(st_in[t]);
         repeat (5) @(negedge clk);
         check({5'h0, batt_lamp_green_r, batt_lamp_orange_r, dc_input_lamp_green_r},
               {5'h0, st_ex[t]}, "steady lamps");
      end
      // Low battery with power on blinks; with the switch on battery alone it flashes.
      for (int m = 0; m < 2; m++) begin
         set_stat(m == 0 ? 6'h06 : 6'h05);
         repeat (5) @(negedge clk);
         n_or = 0;
         repeat (16) begin
            @(negedge clk);
            n_or += batt_lamp_orange_r;
         end
         check(n_or[7:0], m == 0 ? 8'h08 : 8'h04, "battery lamp lit count");
      end
      // Each flag but the last with a random lower-priority flag beside it, random status on DC.
      for (int i = 0; i < NUM_FAULTS; i++) begin
         do_reset();
         r = $random(seed);
         f = '0;
         f[i] = 1'b1;
         if (i < NUM_FAULTS - 1) f[i + 1 + (r[15:0] % (NUM_FAULTS - 1 - i))] = 1'b1;
         exp = code_of(i);
         set_stat({1'b1, r[20:16]});
         fault_flags <= f;
         repeat (5) @(negedge clk);
         check(fault_code_r, exp, "latched code");
         check({7'h0, fault_active_r}, 8'h01, "fault flag");
         exp_q.push_back({1'b1, exp});
         if (i == 0) exp_q.push_back({1'b1, exp});
         wait_q();
         check({7'h0, dc_input_lamp_green_r}, 8'h00, "green lit in fault");
         @(posedge clk);
         fault_flags <= ~f;
         repeat (5) @(negedge clk);
         check(fault_code_r, exp, "code after flag change");
      end
      do_reset();
      @(negedge clk);
      check({7'h0, fault_active_r}, 8'h00, "cleared by reset");
      close_out();
   end
endmodule
